// ### ttsa_regs.vh
// Constants for the tag type select and abort command interpreter
`ifndef TTSA_REGS_VH
`define TTSA_REGS_VH
`define TTSA_CMD_SELECT      8'h04
`define TTSA_CMD_ABORT       8'h02
`define TTSA_LEN_SELECT      8'h06
`define TTSA_LEN_ABORT       8'h04
`define TTSA_LEN_RESP        8'h06
`define TTSA_CHAN_MSB        3
`define TTSA_CHAN_LSB        1
`define TTSA_TOGGLE_BIT      0
`define TTSA_CHANS           8
`define TTSA_HDR_TCP         4'h2
`define TTSA_HDR_NONE        4'h0
`define TTSA_RSVD_MSB        7
`define TTSA_RSVD_LSB        4
`define TTSA_PROX_HI         8'h34
`define TTSA_ASCII_NINE      8'h39
`define TTSA_TYPE_RESET      16'h3839
`define TTSA_TYPE_GEN_VIC    16'h3230
`define TTSA_TYPE_GEN_PROX   16'h3430
`define TTSA_TYPE_GEN_UHF    16'h3830
`define TTSA_ST_OK           8'h00
`define TTSA_ST_BAD          8'h04
`define TTSA_ACC_UID_VIC     2'h1
`define TTSA_ACC_UID_PROX    2'h2
`define TTSA_ACC_UID_UHF     2'h3
`define TTSA_ACC_FULL        2'h0
`define TTSA_UID_LEN_VIC     4'h8
`define TTSA_UID_LEN_PROX    4'h7
`define TTSA_UID_LEN_PROX_S  4'h4
`define TTSA_UID_BITS_UHF    7'h60
`endif

// ### ttsa_type_store.v
// Per-channel tag type store with registered read port
`timescale 1ns/1ns
`include "ttsa_regs.vh"
module ttsa_type_store (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_we,
  input  wire [2:0]  i_waddr,
  input  wire [15:0] i_wdata,
  input  wire [2:0]  i_raddr,
  output reg  [15:0] o_rdata
);
  reg [15:0] mem [0:`TTSA_CHANS-1];
  integer    k;

  // Write port and registered read; reset loads the head-default code
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < `TTSA_CHANS; k = k + 1)
        mem[k] <= `TTSA_TYPE_RESET;
      o_rdata <= `TTSA_TYPE_RESET;
    end else begin
      if (i_we)
        mem[i_waddr] <= i_wdata;
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // ttsa_type_store

// ### ttsa_core.v
// Tag type select and abort command interpreter
// Function
// [R01] Select command carries type as two ASCII bytes, high first; stored per channel
// [R02] Generic vicinity code only fetches the read-only identifier
// [R03] Host gives even block count, at most 7, for 8-byte-block type
// [R04] Host gives contiguous start address for word commands on that type
// [R05] Type code with low character nine uses the head default type
// [R06] Proximity types accept 4-byte or 7-byte identifiers
// [R07] Generic proximity code: read-only code 4 or 7 bytes, no memory
// [R08] Generic UHF code: read-only code up to 96 bits, no memory
// [R09] Two length bytes only present on TCP/IP transports
// [R10] Abort command stops the command running on that channel
// [R11] Host should set a fixed type where the plant uses one type
// [R12] Abort telegram length 4; byte 3 carries channel and toggle
// [R13] Abort response length 6: echo code, channel, toggle, status, counter
`timescale 1ns/1ns
`include "ttsa_regs.vh"
module ttsa_core (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire        i_tcp_mode,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  input  wire        i_rx_last,
  input  wire        i_tx_ready,
  input  wire [7:0]  i_busy,
  input  wire [2:0]  i_head_sel,
  input  wire [3:0]  i_head_uid_len,
  output wire        o_rx_ready,
  output reg         o_tx_valid,
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_last,
  output reg  [7:0]  o_abort,
  output reg         o_type_we,
  output reg  [2:0]  o_type_chan,
  output reg  [15:0] o_type_code,
  output reg  [15:0] o_head_type,
  output reg         o_head_use_default,
  output reg  [1:0]  o_head_access,
  output reg         o_head_uid_ok,
  output reg  [6:0]  o_head_uid_max
);
  localparam S_RX   = 2'b00;
  localparam S_EXEC = 2'b01;
  localparam S_TX   = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [3:0]  idx;
  reg  [3:0]  hdr;
  reg  [7:0]  cmd;
  reg  [7:0]  chbyte;
  reg  [7:0]  type_hi;
  reg  [7:0]  type_lo;
  reg  [7:0]  status;
  reg  [7:0]  reply_cnt;
  reg  [7:0]  tx_byte;
  reg         tx_end;
  reg  [3:0]  tidx;
  reg         bad_frame;
  wire [15:0] stored_type;
  wire [2:0]  chan = chbyte[`TTSA_CHAN_MSB:`TTSA_CHAN_LSB];

  assign o_rx_ready = (state == S_RX);

  // Length bytes precede the code only on the TCP/IP transports;
  // without them the frame length cannot be checked
  always @* begin
    hdr = i_tcp_mode ? `TTSA_HDR_TCP : `TTSA_HDR_NONE; // [R09]
  end

  // State sequencing
  always @* begin
    next_state = state;
    case (state)
      S_RX:    if (i_rx_valid && i_rx_last) next_state = S_EXEC;
      S_EXEC:  next_state = S_TX;
      S_TX:    if (i_tx_ready && o_tx_last) next_state = S_RX;
      default: next_state = S_RX;
    endcase
  end

  // Capture telegram bytes by position after the length header
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= S_RX;
      idx       <= 4'h0;
      cmd       <= 8'h00;
      chbyte    <= 8'h00;
      type_hi   <= 8'h00;
      type_lo   <= 8'h00;
      bad_frame <= 1'b0;
    end else begin
      state <= next_state;
      if (state == S_RX && i_rx_valid) begin
        idx <= i_rx_last ? 4'h0 : idx + 4'h1;
        if (idx == hdr)
          cmd <= i_rx_data;
        if (idx == hdr + 4'h1)
          chbyte <= i_rx_data; // [R12]
        if (idx == hdr + 4'h2)
          type_hi <= i_rx_data; // [R01]
        if (idx == hdr + 4'h3)
          type_lo <= i_rx_data; // [R01]
        // Header length byte checked against both the select and abort sizes, whatever the code
        if (idx == 4'h0)
          bad_frame <= 1'b0;
        if (i_tcp_mode && idx == 4'h1 && i_rx_data != `TTSA_LEN_SELECT
            && i_rx_data != `TTSA_LEN_ABORT)
          bad_frame <= 1'b1;
      end
    end
  end

  // Execute: abort pulse, type store write, status and reply counter
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_abort     <= 8'h00;
      o_type_we   <= 1'b0;
      o_type_chan <= 3'h0;
      o_type_code <= `TTSA_TYPE_RESET;
      status      <= `TTSA_ST_OK;
      reply_cnt   <= 8'h00;
    end else begin
      o_abort   <= 8'h00;
      o_type_we <= 1'b0;
      if (state == S_EXEC) begin
        reply_cnt <= reply_cnt + 8'h01;
        status    <= `TTSA_ST_OK;
        if (bad_frame || chbyte[`TTSA_RSVD_MSB:`TTSA_RSVD_LSB] != 4'h0) begin
          status <= `TTSA_ST_BAD; // [R12]
        end else if (cmd == `TTSA_CMD_ABORT) begin
          o_abort[chan] <= 1'b1; // [R10]
        end else if (cmd == `TTSA_CMD_SELECT) begin
          o_type_we   <= 1'b1; // [R01]
          o_type_chan <= chan;
          o_type_code <= {type_hi, type_lo};
        end else begin
          status <= `TTSA_ST_BAD;
        end
      end
    end
  end

  // Response byte picked from the transmit index; registered below so data
  // leaves a flop, at the cost of one mux in front of it
  always @* begin
    case (tidx - hdr)
      4'hE:    tx_byte = 8'h00; // [R09]
      4'hF:    tx_byte = `TTSA_LEN_RESP;
      4'h0:    tx_byte = cmd; // [R13]
      4'h1:    tx_byte = chbyte;
      4'h2:    tx_byte = status;
      4'h3:    tx_byte = reply_cnt;
      default: tx_byte = 8'h00;
    endcase
    tx_end = (tidx == hdr + 4'h3);
  end

  // Response transmitter with registered data
  // Stalls hold every output: no S_TX branch is taken without ready
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tidx       <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      o_tx_last  <= 1'b0;
    end else if (state == S_EXEC) begin
      tidx       <= 4'h1;
      o_tx_valid <= 1'b1;
      o_tx_data  <= i_tcp_mode ? 8'h00 : cmd;
      o_tx_last  <= 1'b0;
    end else if (state == S_TX && i_tx_ready) begin
      tidx       <= tidx + 4'h1;
      o_tx_valid <= !o_tx_last;
      o_tx_last  <= tx_end; // [R13]
      o_tx_data  <= tx_byte; // [R13]
    end
  end

  // Per-channel type memory; reads the head being served
  ttsa_type_store u_store (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_we    (o_type_we),
    .i_waddr (o_type_chan),
    .i_wdata (o_type_code),
    .i_raddr (i_head_sel),
    .o_rdata (stored_type)
  );

  // Head view of the selected type; generic codes limit access
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_head_type        <= `TTSA_TYPE_RESET;
      o_head_use_default <= 1'b1;
      o_head_access      <= `TTSA_ACC_FULL;
      o_head_uid_ok      <= 1'b0;
      o_head_uid_max     <= 7'h00;
    end else begin
      o_head_type        <= stored_type;
      o_head_use_default <= (stored_type[7:0] == `TTSA_ASCII_NINE); // [R05]
      o_head_uid_ok      <= 1'b1;
      o_head_uid_max     <= {3'h0, i_head_uid_len};
      o_head_access      <= `TTSA_ACC_FULL;
      if (stored_type == `TTSA_TYPE_GEN_VIC) begin
        o_head_access  <= `TTSA_ACC_UID_VIC; // [R02]
        o_head_uid_max <= {3'h0, `TTSA_UID_LEN_VIC};
      end else if (stored_type[15:8] == `TTSA_PROX_HI) begin
        // Either identifier length is legal on proximity heads
        o_head_uid_ok  <= (i_head_uid_len == `TTSA_UID_LEN_PROX) ||
                          (i_head_uid_len == `TTSA_UID_LEN_PROX_S); // [R06]
        if (stored_type == `TTSA_TYPE_GEN_PROX)
          o_head_access <= `TTSA_ACC_UID_PROX; // [R07]
      end else if (stored_type == `TTSA_TYPE_GEN_UHF) begin
        o_head_access  <= `TTSA_ACC_UID_UHF; // [R08]
        o_head_uid_max <= `TTSA_UID_BITS_UHF;
      end
    end
  end
endmodule // ttsa_core

// ### ttsa_core_sva.sv
// Port checker for the tag type select and abort interpreter
`timescale 1ns/1ns
`include "ttsa_regs.vh"
module ttsa_core_sva (
  input logic        i_clk,
  input logic        i_nrst,
  input logic        i_rx_valid,
  input logic        i_rx_last,
  input logic        i_tx_ready,
  input logic        o_rx_ready,
  input logic        o_tx_valid,
  input logic [7:0]  o_tx_data,
  input logic [7:0]  o_abort,
  input logic        o_type_we,
  input logic [15:0] o_head_type,
  input logic        o_head_use_default,
  input logic [1:0]  o_head_access,
  input logic [6:0]  o_head_uid_max
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Last command byte taken, reply starts two cycles on
  sequence s_last; i_rx_valid && o_rx_ready && i_rx_last; endsequence
  sequence s_reply; ##2 o_tx_valid; endsequence
  chk_reply_start: assert property (s_last |-> s_reply)
    else $error("reply late");
  chk_rx_refused: assert property (o_tx_valid |-> !o_rx_ready)
    else $error("byte taken during reply");
  chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped");
  chk_abort_onehot: assert property (o_abort != 8'h00 |-> $onehot(o_abort) && o_tx_valid)
    else $error("abort not one channel");
  chk_abort_pulse: assert property (o_abort != 8'h00 |=> o_abort == 8'h00)
    else $error("abort too long");
  chk_store_pulse: assert property (o_type_we |=> !o_type_we)
    else $error("store too long");
  chk_gen_vic: assert property (o_head_type == `TTSA_TYPE_GEN_VIC |-> o_head_access == 2'h1)
    else $error("vicinity access");
  chk_gen_prox: assert property (o_head_type == `TTSA_TYPE_GEN_PROX |-> o_head_access == 2'h2)
    else $error("proximity access");
  chk_gen_uhf: assert property (o_head_type == `TTSA_TYPE_GEN_UHF |-> o_head_uid_max == 7'h60)
    else $error("uhf code size");
  chk_head_default: assert property (o_head_type[7:0] == 8'h39 |-> o_head_use_default)
    else $error("default not used");
endmodule // ttsa_core_sva

// ### ttsa_host_model.sv
// Host side model: sends command telegrams, collects replies
`timescale 1ns/1ns
module ttsa_host_model (
  input  logic       i_clk,
  input  logic       i_ready,
  input  logic       i_tv,
  input  logic [7:0] i_td,
  input  logic       i_tl,
  output logic       o_valid,
  output logic [7:0] o_data,
  output logic       o_last,
  output logic       o_tready
);
  logic [8:0] rq[$];
  logic       slow = 1'h0;
  logic       rs, tv, tl;
  logic [7:0] td;
  logic [1:0] n = 2'h0;
  initial {o_valid, o_data, o_last, o_tready} = 11'h000;
  // Mid-cycle sample, so the next edge sees settled values
  always @(negedge i_clk) {rs, tv, tl, td} = {i_ready, i_tv, i_tl, i_td};
  // Take reply bytes; slow mode stalls three cycles in four
  always @(posedge i_clk) begin
    if (tv && o_tready) rq.push_back({tl, td});
    n <= n + 2'h1;
    o_tready <= !slow || n == 2'h0;
  end
  // Only select, abort and an unknown code: no block counts or addresses sent
  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      o_valid <= 1'h1;
      o_data <= q[i];
      o_last <= i == q.size() - 1;
      do @(posedge i_clk); while (!rs);
    end
    o_valid <= 1'h0;
    o_data <= ~q[q.size() - 1]; // Released line must not keep the old byte
    o_last <= 1'h0;
  endtask
endmodule // ttsa_host_model

// ### tag_type_select_and_abort_bench.sv
// Self-checking bench for the tag type select and abort interpreter
`timescale 1ns/1ns
`include "ttsa_regs.vh"
module tag_type_select_and_abort_bench;
  logic        i_clk = 1'h0, i_nrst = 1'h0, i_tcp_mode = 1'h1, have = 1'h0;
  logic [7:0]  i_busy = 8'h00, ab, cnt;
  logic [2:0]  i_head_sel = 3'h0;
  logic [3:0]  i_head_uid_len = 4'h4;
  logic [18:0] tw;
  logic [31:0] seed = 32'h99BBFB69;
  wire         i_rx_valid, i_rx_last, i_tx_ready, o_rx_ready, o_tx_valid, o_tx_last;
  wire         o_type_we, o_head_use_default, o_head_uid_ok;
  wire  [7:0]  i_rx_data, o_tx_data, o_abort;
  wire  [2:0]  o_type_chan;
  wire  [15:0] o_type_code, o_head_type;
  wire  [1:0]  o_head_access;
  wire  [6:0]  o_head_uid_max;
  logic [15:0] tys [5] = '{16'h3230, 16'h3430, 16'h3830, 16'h3431, 16'h3839};
  logic [1:0]  acs [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  int          bad_count = 0, checks = 0;
  ttsa_core u_ttsa_core (.*);
  ttsa_host_model u_host (.i_clk(i_clk), .i_ready(o_rx_ready), .i_tv(o_tx_valid),
    .i_td(o_tx_data), .i_tl(o_tx_last), .o_valid(i_rx_valid), .o_data(i_rx_data),
    .o_last(i_rx_last), .o_tready(i_tx_ready));
  initial forever #2 i_clk = ~i_clk;
  // Remember the last store and abort pulses
  always @(posedge i_clk) begin
    if (o_type_we) tw <= {o_type_chan, o_type_code};
    if (o_abort != 8'h00) ab <= o_abort;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [19:0] g, x, input string w);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t: %s got %h exp %h", $time, w, g, x);
    end
  endtask
  // Send one telegram, build the expected reply, compare byte by byte
  task automatic cmd(input logic [7:0] code, b3, input logic [15:0] ty, input int bad);
    logic [7:0] q[$], e[$];
    q = {code, b3};
    if (code == `TTSA_CMD_SELECT) q = {q, ty[15:8], ty[7:0]};
    if (i_tcp_mode) q = {8'h00, 8'(q.size() + 2 + (bad == 1)), q};
    e = {code, b3, bad ? `TTSA_ST_BAD : `TTSA_ST_OK};
    if (i_tcp_mode) e = {8'h00, `TTSA_LEN_RESP, e};
    ab = 8'h00;
    u_host.send(q);
    for (int n = 0; n < 300 && u_host.rq.size() <= e.size(); n++) @(posedge i_clk);
    if (!have) cnt = u_host.rq[e.size()][7:0]; // Start value is free, steps are not
    have = 1'h1;
    e.push_back(cnt++);
    for (int n = 0; n < e.size(); n++) chk(u_host.rq[n], {n == e.size() - 1, e[n]}, "reply");
    u_host.rq.delete();
  endtask
  // Point the head at a channel and compare its derived levels
  task automatic head(input logic [2:0] ch, input int i);
    i_head_sel <= ch;
    repeat (4) @(posedge i_clk);
    chk(o_head_type, tys[i], "type");
    chk(o_head_use_default, tys[i][7:0] == 8'h39, "default");
    if (i < 4) chk(o_head_access, acs[i], "access");
    if (i == 2) chk(o_head_uid_max, 7'h60, "uid max");
    for (int l = 4; i == 1 && l < 8; l++) begin
      i_head_uid_len <= l[3:0];
      repeat (4) @(posedge i_clk);
      chk(o_head_uid_ok, l == 4 || l == 7, "uid ok");
    end
  endtask
  task automatic summarize;
    $display("Checks %0d, errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'h1;
    @(posedge i_clk);
    chk(o_head_type, `TTSA_TYPE_RESET, "reset type");
    // Abort every channel, random toggle, host stalling at random
    for (int c = 0; c < 8; c++) begin
      seed = lfsr(seed);
      u_host.slow = seed[1];
      i_busy <= seed[15:8];
      cmd(`TTSA_CMD_ABORT, {4'h0, c[2:0], seed[0]}, 16'h0000, 0);
      chk(ab, 8'h01 << c, "abort");
    end
    // Every generic code, a fixed type and the head default
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      cmd(`TTSA_CMD_SELECT, {4'h0, seed[3:0]}, tys[i], 0);
      chk(tw, {seed[3:1], tys[i]}, "store");
      head(seed[3:1], i);
    end
    i_tcp_mode <= 1'h0;
    @(posedge i_clk);
    cmd(`TTSA_CMD_ABORT, 8'h0B, 16'h0000, 0);
    chk(ab, 8'h20, "abort");
    i_tcp_mode <= 1'h1;
    @(posedge i_clk);
    cmd(`TTSA_CMD_ABORT, 8'h02, 16'h0000, 1);
    chk(ab, 8'h00, "bad length abort");
    cmd(`TTSA_CMD_ABORT, 8'h12, 16'h0000, 2);
    chk(ab, 8'h00, "reserved bit abort");
    cmd(8'h10, 8'h04, 16'h0000, 2);
    chk(ab, 8'h00, "unknown code abort");
    summarize;
  end
endmodule // tag_type_select_and_abort_bench
bind ttsa_core ttsa_core_sva u_sva (.*);
